// ==== hw/sac_pkg.sv ====
// Package with register map, field layout and timing constants for the converter control
package sac_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CTRLB = 8'h04;
	localparam logic [7:0] ADDR_CTRLC = 8'h08;
	localparam logic [7:0] ADDR_CTRLD = 8'h0c;
	localparam logic [7:0] ADDR_CHAN = 8'h10;
	localparam logic [7:0] ADDR_COMMAND = 8'h14;
	localparam logic [7:0] ADDR_EVCTRL = 8'h18;
	localparam logic [7:0] ADDR_INTCTRL = 8'h1c;
	localparam logic [7:0] ADDR_INTFLAG = 8'h20;
	localparam logic [7:0] ADDR_DBGCTRL = 8'h24;
	localparam logic [7:0] ADDR_RESULT = 8'h28;
	localparam logic [7:0] ADDR_WINLT = 8'h2c;
	localparam logic [7:0] ADDR_WINHT = 8'h30;
	localparam logic [7:0] ADDR_CTRLE = 8'h34;

	// Control register bit positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_CONT_BIT = 1;
	localparam int CTRL_RES_BIT = 2;
	localparam int CTRLD_VARY_BIT = 4;

	// Reset values
	localparam logic [1:0] REF_RESET = 2'h0;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam logic [3:0] CHAN_RESET = 4'h0;

	// Last pin code and the channel codes beyond the twelve pins
	localparam logic [3:0] CHAN_PIN_LAST = 4'hb;
	localparam logic [3:0] CHAN_GND = 4'hc;
	localparam logic [3:0] CHAN_INTREF = 4'hd;
	localparam logic [3:0] CHAN_TEMP = 4'he;

	// Conversion timing in converter clock cycles, and the largest accumulated sample count
	localparam logic [4:0] CONV_CYCLES = 5'h0d;
	localparam logic [4:0] SAMPLE_CYCLE = 5'h02;
	localparam logic [6:0] ACC_MAX = 7'h40;

	localparam logic [9:0] MAX_CODE_10 = 10'h3ff;
	localparam logic [7:0] MAX_CODE_8 = 8'hff;

	typedef enum logic [2:0] {
		WIN_NONE = 3'h0,
		WIN_BELOW = 3'h1,
		WIN_ABOVE = 3'h2,
		WIN_INSIDE = 3'h3,
		WIN_OUTSIDE = 3'h4
	} sac_win_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b10,
		ST_DELAY = 2'b11
	} sac_state_t;

	// Settings latched towards the analog core
	typedef struct packed {
		logic power_on;
		logic [1:0] reference_select;
		logic [3:0] input_channel_select;
		logic low_res;
	} sac_analog_t;
endpackage

// ==== hw/sac_ctrl.sv ====
// Control logic for a 10-bit successive approximation converter with APB registers
//
// Operation
// - Result is right aligned, unused upper bits read zero.
// - Core powered and active only while the enable bit is set.
// - Reference and channel reach the core only once enabled.
// - Resolution select chooses 8-bit or 10-bit conversion.
// - Conversion starts from software command or routed event.
// - Event starts accepted only while event start input bit set.
// - Continuous conversion bit selects free-running over single mode.
// - Consecutive results summed, count selectable up to 64 samples.
// - Configurable inter-sample delay, optionally randomly varied per sample.
// - Window compare restricts interrupt to below, above, inside, outside.
// - Interrupt raised when a conversion completes.
// - Channel select covers twelve pins, ground, internal reference, temperature.
// - Reference select resets to the internal reference.
// - Converter clock comes from prescaler dividing the peripheral clock.
// - Touch controller, when enabled, drives the converter entirely; sample count, prescaler and delay still come from own registers.
// - Converter stops while the processor is halted by the debugger.
// - Run-while-halted bit keeps converter running during halt.
// - Codes run from zero to two to the resolution minus one.
// - Start bit reads one during conversion, cleared at single completion.
// - A conversion lasts 13 converter clock cycles plus delays.
// - Result-ready cleared by result read or writing one.
// - Free-running mode starts the next conversion immediately.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module sac_ctrl
	import sac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic start_event,
	input wire logic debug_halt,
	input wire logic touch_controller_en,
	input wire logic touch_controller_start,
	input wire sac_analog_t touch_controller_cfg,
	output sac_analog_t analog_cfg,
	output logic sample_hold,
	input wire logic [9:0] core_code,
	output logic [15:0] touch_controller_result,
	output logic irq
);
	logic enable;
	logic continuous_conversion;
	logic resolution_select;
	logic [2:0] accumulate_count;
	logic [1:0] reference_select;
	logic [2:0] clock_divider_select;
	logic [3:0] input_channel_select;
	logic [3:0] sample_delay;
	logic auto_delay_vary;
	logic event_start_input;
	logic run_while_halted;
	logic result_ready_ie;
	logic result_ready;
	logic [2:0] win_mode;
	logic [15:0] win_low;
	logic [15:0] win_high;
	logic [15:0] result;
	logic [15:0] acc;
	logic [6:0] acc_num;
	logic start_conversion_cmd;
	logic pending;
	sac_state_t state;
	logic [7:0] div_cnt;
	logic [4:0] cyc;
	logic [3:0] dly_cnt;
	logic [7:0] lfsr;
	logic event_q;
	logic [15:0] next_acc;

	wire apb_wr = psel && penable && pwrite;
	wire apb_rd = psel && penable && !pwrite;
	wire run = clk_en && (!debug_halt || run_while_halted);
	wire own_en = enable && !touch_controller_en;
	wire core_en = touch_controller_en ? touch_controller_cfg.power_on : enable;
	wire low_res = touch_controller_en ? touch_controller_cfg.low_res : resolution_select;
	wire event_edge = start_event && !event_q;
	wire sw_start = apb_wr && paddr == ADDR_COMMAND && pwdata[0];
	wire ev_start = event_start_input && event_edge;
	wire start_req = touch_controller_en ? touch_controller_start : (sw_start || ev_start);
	wire adc_tick = (div_cnt == div_limit(clock_divider_select));
	wire last_cycle = state == ST_CONV && adc_tick && cyc == CONV_CYCLES - 5'h01;
	wire last_sample = acc_num == samples_of(accumulate_count) - 7'h01;
	wire done = last_cycle && last_sample;

	// Prescaler top count for divide by 2, 4 ... 256
	function automatic logic [7:0] div_limit(input logic [2:0] sel);
		logic [8:0] d;
		d = 9'h002 << sel;
		div_limit = 8'(d - 9'h001);
	endfunction

	// Samples per result: 1, 2, 4 ... 64
	function automatic logic [6:0] samples_of(input logic [2:0] sel);
		samples_of = (sel > 3'h6) ? ACC_MAX : 7'(7'h01 << sel);
	endfunction

	// Core code masked to the selected resolution
	function automatic logic [9:0] trim_code(input logic [9:0] c, input logic lr);
		trim_code = lr ? {2'h0, c[9:2] & MAX_CODE_8} : (c & MAX_CODE_10);
	endfunction

	// Window compare of a finished result
	function automatic logic win_hit(input logic [2:0] m, input logic [15:0] r,
		input logic [15:0] lo, input logic [15:0] hi);
		case (m)
			WIN_NONE: win_hit = 1'b1;
			WIN_BELOW: win_hit = r < lo;
			WIN_ABOVE: win_hit = r > hi;
			WIN_INSIDE: win_hit = r >= lo && r <= hi;
			WIN_OUTSIDE: win_hit = r < lo || r > hi;
			default: win_hit = 1'b0;
		endcase
	endfunction

	assign next_acc = acc + {6'h00, trim_code(core_code, low_res)};

	// Register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable <= 1'b0;
			continuous_conversion <= 1'b0;
			resolution_select <= 1'b0;
			accumulate_count <= 3'h0;
			reference_select <= REF_RESET;
			clock_divider_select <= DIV_RESET;
			input_channel_select <= CHAN_RESET;
			sample_delay <= 4'h0;
			auto_delay_vary <= 1'b0;
			event_start_input <= 1'b0;
			run_while_halted <= 1'b0;
			result_ready_ie <= 1'b0;
			win_mode <= 3'h0;
			win_low <= 16'h0000;
			win_high <= 16'h0000;
		end else if (clk_en && apb_wr) begin
			case (paddr)
				ADDR_CTRL: begin
					enable <= pwdata[CTRL_ENABLE_BIT];
					continuous_conversion <= pwdata[CTRL_CONT_BIT];
					resolution_select <= pwdata[CTRL_RES_BIT];
				end
				ADDR_CTRLB: accumulate_count <= pwdata[2:0];
				ADDR_CTRLC: begin
					clock_divider_select <= pwdata[2:0];
					reference_select <= pwdata[5:4];
				end
				ADDR_CTRLD: begin
					sample_delay <= pwdata[3:0];
					auto_delay_vary <= pwdata[CTRLD_VARY_BIT];
				end
				ADDR_CHAN: begin
					if (pwdata[3:0] <= CHAN_TEMP) begin
						input_channel_select <= pwdata[3:0];
					end
				end
				ADDR_EVCTRL: event_start_input <= pwdata[0];
				ADDR_INTCTRL: result_ready_ie <= pwdata[0];
				ADDR_DBGCTRL: run_while_halted <= pwdata[0];
				ADDR_CTRLE: win_mode <= pwdata[2:0];
				ADDR_WINLT: win_low <= pwdata[15:0];
				ADDR_WINHT: win_high <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Event edge detection and delay randomiser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_q <= 1'b0;
			lfsr <= 8'h01;
		end else if (clk_en) begin
			event_q <= start_event;
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		end
	end

	// Prescaler held at zero when idle or disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 8'h00;
		end else if (run) begin
			if (!core_en || state == ST_IDLE || adc_tick) begin
				div_cnt <= 8'h00;
			end else begin
				div_cnt <= div_cnt + 8'h01;
			end
		end
	end

	// Conversion sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			cyc <= 5'h00;
			dly_cnt <= 4'h0;
			acc <= 16'h0000;
			acc_num <= 7'h00;
		end else if (run) begin
			if (!core_en) begin
				state <= ST_IDLE;
				acc_num <= 7'h00;
			end else begin
				case (state)
					ST_IDLE: begin
						if (pending) begin
							state <= ST_WAIT;
							acc <= 16'h0000;
							acc_num <= 7'h00;
						end
					end
					ST_WAIT: begin
						if (adc_tick) begin
							state <= ST_CONV;
							cyc <= 5'h00;
						end
					end
					ST_CONV: begin
						if (adc_tick) begin
							if (cyc == CONV_CYCLES - 5'h01) begin
								cyc <= 5'h00;
								acc <= next_acc;
								if (!last_sample) begin
									acc_num <= acc_num + 7'h01;
									dly_cnt <= auto_delay_vary ? (sample_delay ^ lfsr[3:0]) :
										sample_delay;
									state <= ST_DELAY;
								end else if (continuous_conversion && !touch_controller_en) begin
									acc <= 16'h0000;
									acc_num <= 7'h00;
								end else begin
									state <= ST_IDLE;
								end
							end else begin
								cyc <= cyc + 5'h01;
							end
						end
					end
					ST_DELAY: begin
						if (adc_tick) begin
							if (dly_cnt == 4'h0) begin
								state <= ST_CONV;
							end else begin
								dly_cnt <= dly_cnt - 4'h1;
							end
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// Start bit and pending start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_conversion_cmd <= 1'b0;
			pending <= 1'b0;
		end else if (run) begin
			if (!core_en) begin
				start_conversion_cmd <= 1'b0;
				pending <= 1'b0;
			end else if (start_req) begin
				start_conversion_cmd <= 1'b1;
				pending <= state == ST_IDLE;
			end else begin
				if (state != ST_IDLE) begin
					pending <= 1'b0;
				end
				if (done && !(continuous_conversion && !touch_controller_en)) begin
					start_conversion_cmd <= 1'b0;
				end
			end
		end
	end

	// Result, flag and settings applied to the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= 16'h0000;
			result_ready <= 1'b0;
			analog_cfg <= '0;
			irq <= 1'b0;
		end else if (clk_en) begin
			if (run && done) begin
				result <= next_acc;
				result_ready <= 1'b1;
				irq <= result_ready_ie && win_hit(win_mode, next_acc, win_low, win_high);
			end else begin
				if ((apb_rd && paddr == ADDR_RESULT) ||
					(apb_wr && paddr == ADDR_INTFLAG && pwdata[0])) begin
					result_ready <= 1'b0;
					irq <= 1'b0;
				end
				if (!result_ready_ie) begin
					irq <= 1'b0;
				end
			end
			if (touch_controller_en) begin
				analog_cfg <= touch_controller_cfg;
			end else begin
				analog_cfg.power_on <= enable;
				if (enable) begin
					analog_cfg.low_res <= resolution_select;
				end
				if (enable && (state == ST_IDLE || last_cycle)) begin
					analog_cfg.reference_select <= reference_select;
					analog_cfg.input_channel_select <= input_channel_select;
				end
			end
		end
	end

	assign sample_hold = state == ST_CONV && cyc == SAMPLE_CYCLE;
	assign touch_controller_result = result;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Read mux
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			ADDR_CTRL: prdata[2:0] = {resolution_select, continuous_conversion, enable};
			ADDR_CTRLB: prdata[2:0] = accumulate_count;
			ADDR_CTRLC: prdata[5:0] = {reference_select, 1'b0, clock_divider_select};
			ADDR_CTRLD: prdata[4:0] = {auto_delay_vary, sample_delay};
			ADDR_CHAN: prdata[3:0] = input_channel_select;
			ADDR_COMMAND: prdata[0] = start_conversion_cmd;
			ADDR_EVCTRL: prdata[0] = event_start_input;
			ADDR_INTCTRL: prdata[0] = result_ready_ie;
			ADDR_INTFLAG: prdata[0] = result_ready;
			ADDR_DBGCTRL: prdata[0] = run_while_halted;
			ADDR_RESULT: prdata[15:0] = result;
			ADDR_WINLT: prdata[15:0] = win_low;
			ADDR_WINHT: prdata[15:0] = win_high;
			ADDR_CTRLE: prdata[2:0] = win_mode;
			default: prdata = 32'h0000_0000;
		endcase
	end

	wire unused_ok = own_en | CHAN_PIN_LAST[0] | CHAN_GND[0] | CHAN_INTREF[0];
endmodule

// ==== test/sac_core_model.sv ====
// Behavioural analog core that hands back the single level input at the sample pulse, whatever the channel
`timescale 1ns/1ps
module sac_core_model
	import sac_pkg::*;
(
	input wire logic pclk,
	input wire sac_analog_t analog_cfg,
	input wire logic sample_hold,
	input wire logic [9:0] level,
	output logic [9:0] core_code
);
	initial core_code = 10'h155;
	always @(posedge pclk) begin
		if (analog_cfg.power_on && sample_hold) begin
			core_code <= level;
		end else if (!analog_cfg.power_on) begin
			core_code <= ~core_code;
		end
	end
endmodule

// ==== test/sac_ctrl_monitor.sv ====
// Port checker for the converter control block
`timescale 1ns/1ps
module sac_ctrl_monitor
	import sac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic debug_halt,
	input wire logic touch_controller_en,
	input wire sac_analog_t touch_controller_cfg,
	input wire sac_analog_t analog_cfg,
	input wire logic sample_hold,
	input wire logic [15:0] touch_controller_result,
	input wire logic irq
);
	logic int_en;
	logic dbg_run;
	logic rd;
	logic wr;
	assign rd = psel && penable && !pwrite;
	assign wr = psel && penable && pwrite && clk_en;
	// Shadows of the interrupt enable and run-while-halted bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_en <= 1'b0;
		end else if (wr && paddr == ADDR_INTCTRL) begin
			int_en <= pwdata[0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbg_run <= 1'b0;
		end else if (wr && paddr == ADDR_DBGCTRL) begin
			dbg_run <= pwdata[0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence hold_start;
		$rose(sample_hold);
	endsequence
	sequence hold_ends;
		sample_hold ##[1:999] !sample_hold;
	endsequence
	chk_apb_answer: assert property (psel |-> pready && !pslverr)
		else $error("apb answer late or in error");
	chk_unmapped_zero: assert property (rd && paddr > ADDR_CTRLE |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_result_aligned: assert property (rd && paddr == ADDR_RESULT |-> prdata ==
		{16'h0, touch_controller_result}) else $error("result read misaligned");
	chk_busy_reads: assert property (rd && paddr == ADDR_COMMAND && sample_hold |-> prdata[0])
		else $error("busy bit low while sampling");
	chk_off_idle: assert property (!touch_controller_en && !analog_cfg.power_on &&
		!$past(analog_cfg.power_on) |-> !sample_hold) else $error("sampling while off");
	chk_cfg_held: assert property ((!touch_controller_en && !analog_cfg.power_on)[*3]
		|-> $stable(analog_cfg)) else $error("core setting moved while off");
	chk_touch_cfg: assert property (touch_controller_en[*2] ##0 $stable(touch_controller_cfg)
		|-> analog_cfg == touch_controller_cfg) else $error("touch setting not applied");
	chk_halt_freeze: assert property ($past(debug_halt && !dbg_run) |-> $stable(sample_hold)
		&& $stable(touch_controller_result)) else $error("converter ran while halted");
	chk_irq_masked: assert property (!int_en && !$past(int_en) |-> !irq)
		else $error("interrupt while disabled");
	chk_hold_width: assert property (hold_start |=> hold_ends)
		else $error("sample pulse width wrong");
endmodule
bind sac_ctrl sac_ctrl_monitor sac_ctrl_monitor_inst (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.debug_halt(debug_halt), .touch_controller_en(touch_controller_en),
	.touch_controller_cfg(touch_controller_cfg), .analog_cfg(analog_cfg),
	.sample_hold(sample_hold), .touch_controller_result(touch_controller_result), .irq(irq));

// ==== test/sac_ctrl_tb_top.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
	$display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module sac_ctrl_tb_top
	import sac_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn, clk_en, psel, penable, pwrite, start_event, debug_halt;
	logic touch_controller_en, touch_controller_start, pready, pslverr, sample_hold, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [9:0] core_code, level;
	logic [9:0] wc [3] = '{10'h80, 10'h200, 10'h380};
	logic [15:0] touch_controller_result;
	sac_analog_t touch_controller_cfg, analog_cfg;
	int failures = 0, checks_done = 0, n_cyc, cyc = 0;
	always #4 pclk = ~pclk;
	sac_ctrl sac_ctrl_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .start_event(start_event), .debug_halt(debug_halt),
		.touch_controller_en(touch_controller_en), .touch_controller_start(touch_controller_start),
		.touch_controller_cfg(touch_controller_cfg), .analog_cfg(analog_cfg),
		.sample_hold(sample_hold), .core_code(core_code),
		.touch_controller_result(touch_controller_result), .irq(irq));
	sac_core_model sac_core_model_inst (.pclk(pclk), .analog_cfg(analog_cfg),
		.sample_hold(sample_hold), .level(level), .core_code(core_code));
	function automatic int nsamp(input logic [2:0] a);
		return (a >= 3'h6) ? 64 : (1 << a);
	endfunction
	function automatic logic [15:0] exp_res(input logic lo, input logic [2:0] a, input logic [9:0] c);
		return 16'(nsamp(a) * (lo ? int'(c[9:2]) : int'(c)));
	endfunction
	function automatic logic win(input int m, input int c);
		case (m)
			1: return c < 'h100;
			2: return c > 'h300;
			3: return c > 'h100 && c < 'h300;
			4: return c < 'h100 || c > 'h300;
			default: return 1'b1;
		endcase
	endfunction
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic poll(input logic [7:0] a, input logic want);
		n_cyc = 0;
		do begin
			xfer(1'b0, a, 32'h0);
			n_cyc += 3;
		end while (rdata[0] !== want && n_cyc < 9000);
		`CHK(rdata[0], want)
	endtask
	task automatic go(input logic [9:0] code);
		level <= code;
		xfer(1'b1, ADDR_COMMAND, 32'h1);
		xfer(1'b0, ADDR_COMMAND, 32'h0);
		`CHK(rdata[0], 1'b1)
		poll(ADDR_COMMAND, 1'b0);
		xfer(1'b0, ADDR_INTFLAG, 32'h0);
		`CHK(rdata[0], 1'b1)
	endtask
	task automatic conv(input logic [31:0] ctl, input logic [2:0] a, input logic [2:0] dv,
		input logic [9:0] code);
		xfer(1'b1, ADDR_CTRLB, {29'h0, a});
		xfer(1'b1, ADDR_CTRLC, {29'h0, dv});
		xfer(1'b1, ADDR_CTRL, ctl);
		go(code);
		`CHK(irq, 1'b0)
		`CHK(n_cyc + 9 >= 13 * (2 << dv) * nsamp(a), 1'b1)
		xfer(1'b0, ADDR_RESULT, 32'h0);
		`CHK(rdata, {16'h0, exp_res(ctl[2], a, code)})
		xfer(1'b0, ADDR_INTFLAG, 32'h0);
		`CHK(rdata[0], 1'b0)
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 90000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		{presetn, clk_en, psel, penable, pwrite, start_event, debug_halt} = 7'h0;
		{touch_controller_en, touch_controller_start} = 2'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		level = 10'h0;
		touch_controller_cfg = 8'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		clk_en <= 1'b1;
		@(posedge pclk);
		void'($urandom(32'h7e18a3cf));
		for (int a = 0; a < 64; a += 4) begin
			xfer(1'b0, 8'(a), 32'h0);
			`CHK(rdata, 32'h0)
		end
		clk_en <= 1'b0;
		xfer(1'b1, ADDR_CTRLB, 32'h5);
		clk_en <= 1'b1;
		xfer(1'b1, 8'h3c, 32'hffffffff);
		xfer(1'b0, ADDR_CTRLB, 32'h0);
		`CHK(rdata, 32'h0)
		xfer(1'b0, 8'h3c, 32'h0);
		`CHK(rdata, 32'h0)
		$display("test reset and refusals done");
		xfer(1'b1, ADDR_CTRLC, 32'h20);
		xfer(1'b1, ADDR_CHAN, 32'h7);
		@(posedge pclk);
		`CHK(analog_cfg, 8'h0)
		xfer(1'b1, ADDR_CTRL, 32'h1);
		for (int c = 0; c < 15; c++) begin
			xfer(1'b1, ADDR_CHAN, 32'(c));
			@(posedge pclk);
			`CHK(analog_cfg.input_channel_select, 4'(c))
		end
		`CHK(analog_cfg.reference_select, 2'h2)
		`CHK(analog_cfg.power_on, 1'b1)
		$display("test channel select done");
		conv(32'h1, 3'h0, 3'h0, 10'h0);
		conv(32'h1, 3'h6, 3'h0, 10'h3ff);
		conv(32'h5, 3'h0, 3'h1, 10'h3ff);
		for (int i = 0; i < 5; i++) begin
			conv({29'h0, 1'($urandom), 2'h1}, 3'($urandom_range(4)), 3'($urandom_range(2)),
				10'($urandom));
		end
		xfer(1'b1, ADDR_CTRLD, 32'h1f);
		conv(32'h1, 3'h2, 3'h0, 10'h2c3);
		xfer(1'b1, ADDR_CTRLD, 32'h0);
		xfer(1'b1, ADDR_CTRLB, 32'h0);
		$display("test conversions done");
		for (int e = 0; e < 2; e++) begin
			xfer(1'b1, ADDR_EVCTRL, 32'(e));
			start_event <= 1'b1;
			@(posedge pclk);
			start_event <= 1'b0;
			poll(ADDR_COMMAND, 1'b0);
			xfer(1'b0, ADDR_INTFLAG, 32'h0);
			`CHK(rdata[0], 1'(e))
			xfer(1'b0, ADDR_RESULT, 32'h0);
		end
		$display("test event start done");
		xfer(1'b1, ADDR_INTCTRL, 32'h1);
		xfer(1'b1, ADDR_WINLT, 32'h100);
		xfer(1'b1, ADDR_WINHT, 32'h300);
		for (int m = 0; m < 5; m++) begin
			xfer(1'b1, ADDR_CTRLE, 32'(m));
			for (int k = 0; k < 3; k++) begin
				go(wc[k]);
				repeat (2) @(posedge pclk);
				`CHK(irq, win(m, int'(wc[k])))
				xfer(1'b1, ADDR_INTFLAG, 32'h1);
				@(posedge pclk);
				`CHK(irq, 1'b0)
			end
		end
		$display("test window done");
		xfer(1'b1, ADDR_CTRL, 32'h3);
		level <= 10'h155;
		xfer(1'b1, ADDR_COMMAND, 32'h1);
		for (int f = 0; f < 2; f++) begin
			poll(ADDR_INTFLAG, 1'b1);
			xfer(1'b1, ADDR_INTFLAG, 32'h1);
		end
		xfer(1'b0, ADDR_COMMAND, 32'h0);
		`CHK(rdata[0], 1'b1)
		xfer(1'b1, ADDR_CTRL, 32'h1);
		poll(ADDR_COMMAND, 1'b0);
		xfer(1'b0, ADDR_RESULT, 32'h0);
		`CHK(rdata, 32'h155)
		$display("test free running done");
		for (int h = 0; h < 2; h++) begin
			xfer(1'b1, ADDR_DBGCTRL, 32'(h));
			xfer(1'b1, ADDR_COMMAND, 32'h1);
			debug_halt <= 1'b1;
			repeat (120) @(posedge pclk);
			xfer(1'b0, ADDR_INTFLAG, 32'h0);
			`CHK(rdata[0], 1'(h))
			debug_halt <= 1'b0;
			poll(ADDR_COMMAND, 1'b0);
			xfer(1'b0, ADDR_RESULT, 32'h0);
		end
		$display("test debug halt done");
		xfer(1'b1, ADDR_CTRL, 32'h0);
		touch_controller_cfg <= 8'hb6;
		level <= 10'h2a5;
		touch_controller_en <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK(analog_cfg, 8'hb6)
		touch_controller_start <= 1'b1;
		@(posedge pclk);
		touch_controller_start <= 1'b0;
		for (int k = 0; k < 3000 && touch_controller_result !== 16'h2a5; k++) @(posedge pclk);
		`CHK(touch_controller_result, 16'h2a5)
		touch_controller_en <= 1'b0;
		$display("test touch control done");
		wrap_up();
	end
endmodule
